/* archive_defines.vh */
// constants for the archive file reader: frame codes, archive layout,
// header values and the crc polynomial.
// assumes the includer works in bytes on a single 20 MHz clock.
//
// Contract
// - request: addr, 14h, 07h, ref type, file, start index, count, crc lo/hi
// - only one sub-request per frame; other byte counts are dropped
// - reference type byte is never checked
// - files 1..12: odd select headers, even archives, six types in order
// - start index picks the first archive entry returned
// - bytes returned equal twice the register count
// - data is one contiguous byte stream, high byte from lower address
// - 300th entry gives position 300, oldest 0, newest 299
// - full archive overwrites oldest; 301st gives 301, oldest 1, newest 0
// - position number counts up per entry, wraps to zero after 9999
// - four header copies per type in a ring, next slot per write
`ifndef ARCHIVE_DEFINES_VH
`define ARCHIVE_DEFINES_VH

// ----------------------------------------------------------------
// frame
// ----------------------------------------------------------------
`define FUNC_RD_REF 8'h14
`define SUB_LEN 8'h07
`define REF_TYPE_RSP 8'h06
`define ZERO_BYTE 8'h00
`define REQ_LEN 4'hC
`define FILE_MAX 8'h0C
`define MAX_REGS 8'h7D
`define BCNT_EXTRA 8'h02
`define SLEN_EXTRA 8'h01
`define RSP_FIXED 9'h007
`define IDX_ADDR 9'h000
`define IDX_FUNC 9'h001
`define IDX_BCNT 9'h002
`define IDX_SLEN 9'h003
`define IDX_REF 9'h004
`define DATA_FIRST 9'h005
`define CRC_INIT 16'hFFFF
`define CRC_GOOD 16'h0000
`define CRC_POLY 16'hA001

// ----------------------------------------------------------------
// archives
// ----------------------------------------------------------------
`define T_CPAR 3'h0
`define T_PAR 3'h1
`define T_EVT 3'h2
`define T_MIN 3'h3
`define T_DAY 3'h4
`define TYPE_LAST 3'h5
`define SZ_PAR 6'h22
`define SZ_EVT 6'h0C
`define SZ_MEAS 6'h28
`define MAX_PAR 16'h012C
`define MAX_EVT 16'h00C8
`define MAX_MIN 16'h2328
`define MAX_DAY 16'h0064
`define MAX_MON 16'h0019
`define BASE_CPAR 19'h0_0000
`define BASE_PAR 19'h0_27D8
`define BASE_EVT 19'h0_4FB0
`define BASE_MIN 19'h0_5910
`define BASE_DAY 19'h5_D750
`define BASE_MON 19'h5_E6F0

// ----------------------------------------------------------------
// header
// ----------------------------------------------------------------
`define HDR_EMPTY 48'h0000_FFFF_FFFF
`define IDX_EMPTY 16'hFFFF
`define POS_MAX 16'h270F
`define ONE16 16'h0001
`define ZERO16 16'h0000
`define HDR_RING_LAST 20'h0_001F
`define HDR_CRC_LO 3'h6
`define HDR_FIRST 3'h0
`define PTR_RESET 12'hFFF

`endif

/* crc16_step.v */
// one byte step of the modbus crc16 (reflected polynomial).
// assumes the caller holds the running value and seeds it itself.
`timescale 1ns/1ps
`include "archive_defines.vh"

module crc16_step (
   input wire [15:0] crc_in,
   input wire [7:0] data_in,
   output reg [15:0] crc_out
);
   integer i;
   always @* begin
      crc_out = crc_in ^ {8'h00, data_in};
      for (i = 0; i < 8; i = i + 1) begin
         if (crc_out[0]) begin
            crc_out = (crc_out >> 1) ^ `CRC_POLY;
         end else begin
            crc_out = crc_out >> 1;
         end
      end
   end
endmodule // crc16_step

/* archive_reader.v */
// archive file reader: parses 14h requests, streams archive or header
// bytes back, keeps the header rings as entries are written.
// assumes a byte-level serial layer on clock_in that flags frame end,
// and an archive store answering one cycle after mem_rd_out.
`timescale 1ns/1ps
`include "archive_defines.vh"

module archive_reader (
   input wire clock_in,
   input wire rst_n_in,
   input wire [7:0] dev_addr_in,
   input wire [7:0] rx_data_in,
   input wire rx_valid_in,
   input wire rx_end_in,
   input wire tx_ready_in,
   input wire entry_write_in,
   input wire [2:0] entry_type_in,
   input wire [7:0] mem_data_in,
   output wire [18:0] mem_addr_out,
   output wire mem_rd_out,
   output wire [7:0] tx_data_out,
   output wire tx_valid_out,
   output wire tx_last_out
);
   // ----------------------------------------------------------------
   // lookup
   // ----------------------------------------------------------------
   function [5:0] size_f(input [2:0] t);
      case (t)
         `T_CPAR, `T_PAR: size_f = `SZ_PAR;
         `T_EVT: size_f = `SZ_EVT;
         default: size_f = `SZ_MEAS;
      endcase
   endfunction
   function [18:0] base_f(input [2:0] t);
      case (t)
         `T_CPAR: base_f = `BASE_CPAR;
         `T_PAR: base_f = `BASE_PAR;
         `T_EVT: base_f = `BASE_EVT;
         `T_MIN: base_f = `BASE_MIN;
         `T_DAY: base_f = `BASE_DAY;
         default: base_f = `BASE_MON;
      endcase
   endfunction
   function [15:0] max_f(input [2:0] t);
      case (t)
         `T_CPAR, `T_PAR: max_f = `MAX_PAR;
         `T_EVT: max_f = `MAX_EVT;
         `T_MIN: max_f = `MAX_MIN;
         `T_DAY: max_f = `MAX_DAY;
         default: max_f = `MAX_MON;
      endcase
   endfunction
   function [15:0] inc_f(input [15:0] v, input [15:0] m);
      inc_f = (v + `ONE16 == m) ? `ZERO16 : v + `ONE16;
   endfunction

   localparam S_RX = 6'b000001;
   localparam S_CHK = 6'b000010;
   localparam S_PREP = 6'b000100;
   localparam S_WAIT = 6'b001000;
   localparam S_CAP = 6'b010000;
   localparam S_TX = 6'b100000;

   reg [5:0] state_r;
   reg [7:0] rxb [0:11];
   reg [3:0] rx_cnt_r;
   reg rx_ovf_r;
   reg [15:0] rx_crc_r;
   reg [2:0] type_r;
   reg hdr_sel_r;
   reg [15:0] start_r;
   reg [6:0] nreg_r;
   reg [8:0] len_r;
   reg [8:0] idx_r;
   reg [15:0] tx_crc_r;
   reg [15:0] hcrc_r;
   reg [2:0] hbyte_r;
   reg hbyte_en_r;
   reg [18:0] mem_addr_r;
   reg mem_rd_r;
   reg [7:0] tx_data_r;
   reg tx_valid_r;
   reg tx_last_r;
   reg [47:0] hdr_mem [0:23];
   reg [23:0] hdr_used_r;
   reg [11:0] wr_ptr_r;

   wire [15:0] rx_crc_nxt;
   wire [15:0] tx_crc_nxt;
   wire [15:0] hcrc_nxt;
   wire [15:0] hcrc_seed = (hbyte_r == `HDR_FIRST) ? `CRC_INIT : hcrc_r;

   crc16_step u_rx_crc (
      .crc_in(rx_crc_r),
      .data_in(rx_data_in),
      .crc_out(rx_crc_nxt)
   );
   crc16_step u_tx_crc (
      .crc_in(tx_crc_r),
      .data_in(tx_data_r),
      .crc_out(tx_crc_nxt)
   );
   crc16_step u_hdr_crc (
      .crc_in(hcrc_seed),
      .data_in(tx_data_r),
      .crc_out(hcrc_nxt)
   );

   // ----------------------------------------------------------------
   // request check
   // ----------------------------------------------------------------
   wire [7:0] file_m1 = rxb[5] - 8'h01;
   wire req_ok = (rx_cnt_r == `REQ_LEN) && !rx_ovf_r
      && (rx_crc_r == `CRC_GOOD)
      && (rxb[0] == dev_addr_in) && (rxb[1] == `FUNC_RD_REF)
      && (rxb[2] == `SUB_LEN)
      // reference type in rxb[3] deliberately not looked at
      && (rxb[4] == `ZERO_BYTE) && (rxb[5] != `ZERO_BYTE)
      && (rxb[5] <= `FILE_MAX)
      && (rxb[8] == `ZERO_BYTE) && (rxb[9] != `ZERO_BYTE)
      && (rxb[9] <= `MAX_REGS);

   // ----------------------------------------------------------------
   // byte source
   // ----------------------------------------------------------------
   wire [8:0] k_full = idx_r - `DATA_FIRST;
   wire [7:0] k_w = k_full[7:0];
   wire [21:0] prod_w = start_r * size_f(type_r);
   wire [21:0] arc_w = prod_w + {3'b000, base_f(type_r)}
      + {14'h0000, k_w};
   wire [19:0] hj_w = {1'b0, start_r, 3'b000} + {12'h000, k_w};
   wire hj_in = (hj_w <= `HDR_RING_LAST);
   wire [4:0] slot_w = {type_r, hj_w[4:3]};
   wire [47:0] hword_w = hdr_used_r[slot_w] ? hdr_mem[slot_w]
      : `HDR_EMPTY;
   wire [47:0] hshift_w = hword_w << {hj_w[2:0], 3'b000};
   wire [8:0] crc_lo_idx = len_r - 9'h002;
   wire [8:0] last_idx = len_r - 9'h001;

   reg [7:0] byte_nxt;
   reg fetch_nxt;
   reg hdr_byte_nxt;
   always @* begin
      byte_nxt = `ZERO_BYTE;
      fetch_nxt = 1'b0;
      hdr_byte_nxt = 1'b0;
      case (idx_r)
         `IDX_ADDR: byte_nxt = dev_addr_in;
         `IDX_FUNC: byte_nxt = `FUNC_RD_REF;
         `IDX_BCNT: byte_nxt = {nreg_r, 1'b0} + `BCNT_EXTRA;
         `IDX_SLEN: byte_nxt = {nreg_r, 1'b0} + `SLEN_EXTRA;
         `IDX_REF: byte_nxt = `REF_TYPE_RSP;
         default: begin
            if (idx_r == crc_lo_idx) begin
               byte_nxt = tx_crc_r[7:0];
            end else if (idx_r == last_idx) begin
               byte_nxt = tx_crc_r[15:8];
            end else if (!hdr_sel_r) begin
               fetch_nxt = 1'b1;
            end else if (hj_in) begin
               // header crc is only right when the copy is read whole
               hdr_byte_nxt = 1'b1;
               byte_nxt = (hj_w[2:0] >= `HDR_CRC_LO)
                  ? (hj_w[0] ? hcrc_r[15:8] : hcrc_r[7:0])
                  : hshift_w[47:40];
            end
         end
      endcase
   end

   // ----------------------------------------------------------------
   // frame sequencer
   // ----------------------------------------------------------------
   always @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_r <= S_RX;
         rx_cnt_r <= 4'h0;
         rx_ovf_r <= 1'b0;
         rx_crc_r <= `CRC_INIT;
         type_r <= 3'h0;
         hdr_sel_r <= 1'b0;
         start_r <= `ZERO16;
         nreg_r <= 7'h00;
         len_r <= 9'h000;
         idx_r <= 9'h000;
         tx_crc_r <= `CRC_INIT;
         hcrc_r <= `CRC_INIT;
         hbyte_r <= 3'h0;
         hbyte_en_r <= 1'b0;
         mem_addr_r <= 19'h0_0000;
         mem_rd_r <= 1'b0;
         tx_data_r <= `ZERO_BYTE;
         tx_valid_r <= 1'b0;
         tx_last_r <= 1'b0;
      end else begin
         case (state_r)
            S_RX: begin
               if (rx_valid_in) begin
                  if (rx_cnt_r < `REQ_LEN) begin
                     rxb[rx_cnt_r] <= rx_data_in;
                     rx_cnt_r <= rx_cnt_r + 4'h1;
                     rx_crc_r <= rx_crc_nxt;
                  end else begin
                     rx_ovf_r <= 1'b1;
                  end
               end
               if (rx_end_in) begin
                  state_r <= S_CHK;
               end
            end
            S_CHK: begin
               // bad frames are dropped silently, as a slave must
               rx_cnt_r <= 4'h0;
               rx_ovf_r <= 1'b0;
               rx_crc_r <= `CRC_INIT;
               if (req_ok) begin
                  type_r <= file_m1[3:1];
                  hdr_sel_r <= ~file_m1[0];
                  start_r <= {rxb[6], rxb[7]};
                  nreg_r <= rxb[9][6:0];
                  len_r <= {1'b0, rxb[9][6:0], 1'b0} + `RSP_FIXED;
                  idx_r <= `IDX_ADDR;
                  tx_crc_r <= `CRC_INIT;
                  state_r <= S_PREP;
               end else begin
                  state_r <= S_RX;
               end
            end
            S_PREP: begin
               if (fetch_nxt) begin
                  mem_addr_r <= arc_w[18:0];
                  mem_rd_r <= 1'b1;
                  state_r <= S_WAIT;
               end else begin
                  tx_data_r <= byte_nxt;
                  tx_valid_r <= 1'b1;
                  tx_last_r <= (idx_r == last_idx);
                  hbyte_r <= hj_w[2:0];
                  hbyte_en_r <= hdr_byte_nxt;
                  state_r <= S_TX;
               end
            end
            S_WAIT: begin
               mem_rd_r <= 1'b0;
               state_r <= S_CAP;
            end
            S_CAP: begin
               tx_data_r <= mem_data_in;
               tx_valid_r <= 1'b1;
               tx_last_r <= 1'b0;
               hbyte_en_r <= 1'b0;
               state_r <= S_TX;
            end
            S_TX: begin
               if (tx_ready_in) begin
                  tx_valid_r <= 1'b0;
                  tx_last_r <= 1'b0;
                  if (idx_r < crc_lo_idx) begin
                     tx_crc_r <= tx_crc_nxt;
                  end
                  if (hbyte_en_r && (hbyte_r < `HDR_CRC_LO)) begin
                     hcrc_r <= hcrc_nxt;
                  end
                  if (tx_last_r) begin
                     state_r <= S_RX;
                  end else begin
                     idx_r <= idx_r + 9'h001;
                     state_r <= S_PREP;
                  end
               end
            end
            default: state_r <= S_RX;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // header rings
   // ----------------------------------------------------------------
   wire [1:0] wp_cur = wr_ptr_r[{entry_type_in, 1'b0} +: 2];
   wire [1:0] wp_new = wp_cur + 2'b01;
   wire [4:0] ws_cur = {entry_type_in, wp_cur};
   wire [4:0] ws_new = {entry_type_in, wp_new};
   wire [47:0] wcur = hdr_used_r[ws_cur] ? hdr_mem[ws_cur] : `HDR_EMPTY;
   wire [15:0] w_pos = wcur[47:32];
   wire [15:0] w_old = wcur[31:16];
   wire [15:0] w_newest = wcur[15:0];
   wire [15:0] w_max = max_f(entry_type_in);
   wire w_empty = (w_newest == `IDX_EMPTY);
   wire [15:0] n_new = w_empty ? `ZERO16 : inc_f(w_newest, w_max);
   // catching up with the oldest means full: drop the oldest
   wire [15:0] o_new = w_empty ? `ZERO16
      : ((n_new == w_old) ? inc_f(w_old, w_max) : w_old);
   wire [15:0] p_new = (w_pos == `POS_MAX) ? `ZERO16
      : w_pos + `ONE16;
   wire we_w = entry_write_in && (entry_type_in <= `TYPE_LAST);

   always @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_ptr_r <= `PTR_RESET;
         hdr_used_r <= 24'h00_0000;
      end else if (we_w) begin
         wr_ptr_r[{entry_type_in, 1'b0} +: 2] <= wp_new;
         hdr_used_r[ws_new] <= 1'b1;
      end
   end

   always @(posedge clock_in) begin
      if (we_w) begin
         hdr_mem[ws_new] <= {p_new, o_new, n_new};
      end
   end

   assign mem_addr_out = mem_addr_r;
   assign mem_rd_out = mem_rd_r;
   assign tx_data_out = tx_data_r;
   assign tx_valid_out = tx_valid_r;
   assign tx_last_out = tx_last_r;
endmodule // archive_reader

/* archive_reader_properties.sv */
// concurrent checks on the archive reader ports: response framing, store
// reads and the transmit handshake.
// assumes it is bound to archive_reader on its single clock domain.
`timescale 1ns/1ps

module archive_reader_properties (
   input wire clock_in,
   input wire rst_n_in,
   input wire [7:0] dev_addr_in,
   input wire tx_ready_in,
   input wire [7:0] mem_data_in,
   input wire [18:0] mem_addr_out,
   input wire mem_rd_out,
   input wire [7:0] tx_data_out,
   input wire tx_valid_out,
   input wire tx_last_out
);
   wire take;
   reg [8:0] idx_r;
   reg [7:0] bcnt_r;
   reg [18:0] last_addr_r;
   reg seen_r;

   assign take = tx_valid_out && tx_ready_in;

   // ---------------------------------------------------------------
   // position of each taken byte within the response
   // ---------------------------------------------------------------
   always @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         idx_r <= 9'h000;
         bcnt_r <= 8'h00;
         last_addr_r <= 19'h0_0000;
         seen_r <= 1'b0;
      end else begin
         if (take) begin
            idx_r <= tx_last_out ? 9'h000 : idx_r + 9'h001;
         end
         if (take && idx_r == 9'h002) begin
            bcnt_r <= tx_data_out;
         end
         if (mem_rd_out) begin
            last_addr_r <= mem_addr_out;
         end
         // a new response may start anywhere in the store
         if (take && tx_last_out) begin
            seen_r <= 1'b0;
         end else if (mem_rd_out) begin
            seen_r <= 1'b1;
         end
      end
   end

   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);

   rd_pulse_a: assert property (mem_rd_out |=> !mem_rd_out)
      else $error("store read held longer than one cycle");
   mem_path_a: assert property (mem_rd_out |-> ##2
      (tx_valid_out && tx_data_out == $past(mem_data_in)))
      else $error("store byte not presented two cycles after read");
   addr_step_a: assert property (
      mem_rd_out && seen_r |-> mem_addr_out == last_addr_r + 19'h0_0001)
      else $error("store addresses not contiguous");
   tx_hold_a: assert property (tx_valid_out && !tx_ready_in |=>
      tx_valid_out && $stable(tx_data_out) && $stable(tx_last_out))
      else $error("tx byte changed before it was taken");
   addr_echo_a: assert property (
      take && idx_r == 9'h000 |-> tx_data_out == dev_addr_in)
      else $error("response does not start with own address");
   func_echo_a: assert property (
      take && idx_r == 9'h001 |-> tx_data_out == 8'h14)
      else $error("response function byte wrong");
   reg_limit_a: assert property (take && idx_r == 9'h002 |->
      tx_data_out >= 8'h04 && tx_data_out <= 8'hFC && !tx_data_out[0])
      else $error("response byte count out of range");
   sub_len_a: assert property (
      take && idx_r == 9'h003 |-> tx_data_out == bcnt_r - 8'h01)
      else $error("sub-response length wrong");
   byte_total_a: assert property (
      take && tx_last_out |-> idx_r == {1'b0, bcnt_r} + 9'h004)
      else $error("response length disagrees with byte count");
   last_idle_a: assert property (take && tx_last_out |=> !tx_valid_out)
      else $error("transmit continued after last byte");
endmodule // archive_reader_properties

/* archive_store.sv */
// behavioural archive store answering byte reads from the reader.
// assumes reads are one-cycle pulses with the address already valid.
`timescale 1ns/1ps

module archive_store (
   input wire clock_in,
   input wire mem_rd_in,
   input wire [18:0] mem_addr_in,
   output reg [7:0] mem_data_out
);
   initial mem_data_out = 8'h00;

   // stale data toggles so a capture one cycle late cannot pass by chance
   always @(posedge clock_in) begin
      if (mem_rd_in) begin
         mem_data_out <= mem_addr_in[7:0] ^ mem_addr_in[15:8]
            ^ {5'h00, mem_addr_in[18:16]} ^ 8'hA5;
      end else begin
         mem_data_out <= ~mem_data_out;
      end
   end
endmodule // archive_store

/* testbench.sv */
// self-checking bench for the archive reader: requests, refusals, headers.
// assumes archive_store as the store and the reader's defines on the path.
`timescale 1ns/1ps
`include "archive_defines.vh"

module testbench;
   localparam [7:0] SLAVE = 8'h21;
   reg clock_in = 1'b0;
   reg rst_n_in = 1'b0;
   reg [7:0] rx_data_in = 8'h00;
   reg rx_valid_in = 1'b0;
   reg rx_end_in = 1'b0;
   reg tx_ready_in = 1'b0;
   reg entry_write_in = 1'b0;
   reg [2:0] entry_type_in = 3'h0;
   wire [7:0] mem_data_in;
   wire [18:0] mem_addr_out;
   wire mem_rd_out;
   wire [7:0] tx_data_out;
   wire tx_valid_out;
   wire tx_last_out;
   integer fail_count = 0;
   integer checks_done = 0;
   integer rsp_len;
   reg [7:0] rsp [0:299];
   reg [7:0] req_bcnt = 8'h07;

   always #25 clock_in = ~clock_in;

   archive_reader dut_u (.clock_in(clock_in), .rst_n_in(rst_n_in),
      .dev_addr_in(SLAVE), .rx_data_in(rx_data_in),
      .rx_valid_in(rx_valid_in), .rx_end_in(rx_end_in),
      .tx_ready_in(tx_ready_in), .entry_write_in(entry_write_in),
      .entry_type_in(entry_type_in), .mem_data_in(mem_data_in),
      .mem_addr_out(mem_addr_out), .mem_rd_out(mem_rd_out),
      .tx_data_out(tx_data_out), .tx_valid_out(tx_valid_out),
      .tx_last_out(tx_last_out));
   archive_store store_u (.clock_in(clock_in), .mem_rd_in(mem_rd_out),
      .mem_addr_in(mem_addr_out), .mem_data_out(mem_data_in));

   task tick; begin
      @(posedge clock_in);
      #5;
   end endtask

   task check(input [31:0] got, input [31:0] exp); begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
         fail_count = fail_count + 1;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   end endtask

   task close_out; begin
      if (fail_count == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   end endtask

   function [15:0] crc_add(input [15:0] c, input [7:0] b);
      integer i;
      begin
         crc_add = c ^ {8'h00, b};
         for (i = 0; i < 8; i = i + 1) begin
            crc_add = crc_add[0] ? (crc_add >> 1) ^ 16'hA001 : crc_add >> 1;
         end
      end
   endfunction

   function [7:0] pat(input [18:0] a);
      pat = a[7:0] ^ a[15:8] ^ {5'h00, a[18:16]} ^ 8'hA5;
   endfunction

   // reference type is junk on purpose: it must not matter
   task send_req(input [7:0] adr, input [7:0] fn, input [15:0] file,
      input [15:0] start, input [15:0] cnt, input [7:0] crc_x);
      reg [7:0] f [0:11];
      reg [15:0] c;
      integer i;
      begin
         {f[0], f[1], f[2], f[3]} = {adr, fn, req_bcnt, 8'h5A};
         {f[4], f[5], f[6], f[7]} = {file, start};
         {f[8], f[9]} = cnt;
         c = 16'hFFFF;
         for (i = 0; i < 10; i = i + 1) c = crc_add(c, f[i]);
         {f[11], f[10]} = c ^ {8'h00, crc_x};
         for (i = 0; i < 12; i = i + 1) begin
            rx_data_in = f[i];
            rx_valid_in = 1'b1;
            rx_end_in = (i == 11);
            tick;
         end
         rx_valid_in = 1'b0;
         rx_end_in = 1'b0;
      end
   endtask

   // sink stalls two cycles in four; a byte counts when taken at the edge
   task get_rsp(input integer lim);
      integer n;
      reg done;
      begin
         rsp_len = 0;
         done = 1'b0;
         for (n = 0; n < lim && !done; n = n + 1) begin
            tx_ready_in = n[1];
            @(negedge clock_in);
            if (tx_valid_out === 1'b1 && tx_ready_in) begin
               rsp[rsp_len] = tx_data_out;
               rsp_len = rsp_len + 1;
               done = (tx_last_out === 1'b1);
            end
            tick;
         end
         tx_ready_in = 1'b0;
      end
   endtask

   task check_frame(input integer n);
      reg [15:0] c;
      integer i;
      begin
         check(rsp_len, 2 * n + 7);
         check(rsp[0], SLAVE);
         check(rsp[1], 8'h14);
         check(rsp[2], 2 * n + 2);
         check(rsp[3], 2 * n + 1);
         check(rsp[4], 8'h06);
         c = 16'hFFFF;
         for (i = 0; i < rsp_len; i = i + 1) c = crc_add(c, rsp[i]);
         check(c, 16'h0000);
      end
   endtask

   task t_archives;
      reg [18:0] base;
      integer t, n, sz, k;
      begin
         for (t = 0; t < 6; t = t + 1) begin
            case (t)
               0: base = `BASE_CPAR;
               1: base = `BASE_PAR;
               2: base = `BASE_EVT;
               3: base = `BASE_MIN;
               4: base = `BASE_DAY;
               default: base = `BASE_MON;
            endcase
            sz = (t == 2) ? 12 : (t < 2 ? 34 : 40);
            n = (t == 5) ? 125 : ((t == 2) ? 13 : sz / 2);
            send_req(SLAVE, 8'h14, 2 * t + 2, t + 7, n, 8'h00);
            get_rsp(3000);
            check_frame(n);
            for (k = 0; k < 2 * n; k = k + 1) begin
               check(rsp[5 + k], pat(base + (t + 7) * sz + k));
            end
         end
      end
   endtask

   // broken frames of eight kinds are dropped without a reply
   task t_refuse;
      integer i;
      begin
         for (i = 0; i < 8; i = i + 1) begin
            req_bcnt = (i == 7) ? 8'h0E : 8'h07;
            case (i)
               0: send_req(SLAVE, 8'h14, 6, 0, 2, 8'h01);
               1: send_req(SLAVE, 8'h13, 6, 0, 2, 8'h00);
               2: send_req(SLAVE, 8'h14, 13, 0, 2, 8'h00);
               3: send_req(SLAVE, 8'h14, 6, 0, 126, 8'h00);
               4: send_req(8'h22, 8'h14, 6, 0, 2, 8'h00);
               5: send_req(SLAVE, 8'h14, 0, 0, 2, 8'h00);
               6: send_req(SLAVE, 8'h14, 6, 0, 0, 8'h00);
               default: send_req(SLAVE, 8'h14, 6, 0, 2, 8'h00);
            endcase
            req_bcnt = 8'h07;
            get_rsp(40);
            check(rsp_len, 0);
         end
      end
   endtask

   task write_entries(input [2:0] t, input integer cnt); begin
      entry_type_in = t;
      entry_write_in = 1'b1;
      repeat (cnt) tick;
      entry_write_in = 1'b0;
      tick;
   end endtask

   task hdr_chk(input integer s, input [47:0] exp);
      reg [15:0] c;
      integer i;
      begin
         check({rsp[5 + 8 * s], rsp[6 + 8 * s], rsp[7 + 8 * s]}, exp[47:24]);
         check({rsp[8 + 8 * s], rsp[9 + 8 * s], rsp[10 + 8 * s]}, exp[23:0]);
         c = 16'hFFFF;
         for (i = 0; i < 8; i = i + 1) c = crc_add(c, rsp[5 + 8 * s + i]);
         check(c, 16'h0000);
      end
   endtask

   // entry count as a master works it out from one header copy
   task cnt_chk(input integer s, input [15:0] m, input [15:0] exp);
      reg [15:0] o, nw, n;
      begin
         o = {rsp[7 + 8 * s], rsp[8 + 8 * s]};
         nw = {rsp[9 + 8 * s], rsp[10 + 8 * s]};
         if (o == 16'hFFFF && nw == 16'hFFFF) begin
            n = 16'h0000;
         end else if (o <= nw) begin
            n = nw - o + 16'h0001;
         end else begin
            n = m - o + nw + 16'h0001;
         end
         check(n, exp);
      end
   endtask

   task read_hdr(input [15:0] file); begin
      send_req(SLAVE, 8'h14, file, 0, 16, 8'h00);
      get_rsp(600);
      check_frame(16);
   end endtask

   task t_headers; begin
      read_hdr(11);
      hdr_chk(0, 48'h0000_FFFF_FFFF);
      cnt_chk(0, 25, 0);
      write_entries(3'h2, 1);
      read_hdr(5);
      hdr_chk(0, 48'h0001_0000_0000);
      cnt_chk(0, 200, 1);
      write_entries(3'h1, 300);
      read_hdr(3);
      hdr_chk(3, 48'h012C_0000_012B);
      cnt_chk(3, 300, 300);
      write_entries(3'h1, 1);
      read_hdr(3);
      hdr_chk(0, 48'h012D_0001_0000);
      hdr_chk(3, 48'h012C_0000_012B);
      cnt_chk(0, 300, 300);
      write_entries(3'h4, 10000);
      read_hdr(9);
      hdr_chk(3, 48'h0000_0000_0063);
      cnt_chk(3, 100, 100);
   end endtask

   initial begin
      #(40000 * 50);
      fail_count = fail_count + 1;
      close_out;
   end

   initial begin
      repeat (20) @(posedge clock_in);
      #5;
      rst_n_in = 1'b1;
      tick;
      t_refuse;
      t_archives;
      t_headers;
      close_out;
   end
endmodule // testbench

bind archive_reader archive_reader_properties chk_u (
   .clock_in(clock_in), .rst_n_in(rst_n_in), .dev_addr_in(dev_addr_in),
   .tx_ready_in(tx_ready_in), .mem_data_in(mem_data_in),
   .mem_addr_out(mem_addr_out), .mem_rd_out(mem_rd_out),
   .tx_data_out(tx_data_out), .tx_valid_out(tx_valid_out),
   .tx_last_out(tx_last_out));
